// File: hw/scs_task_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"

// Overview of operation
// [R1] I/O refresh runs at each servo cycle start, before any other work.
// [R2] First copy inputs latched last cycle into the input image.
// [R3] Then update the analogue speed reference outputs of all axes.
// [R4] Then drive digital output pins from the output image.
// [R5] Last, latch present digital input pins for the next cycle.
// [R6] No automatic reaction to I/O; user tasks decide everything.
// [R7] Start without explicit task goes to highest-priority free task.
// [R8] Fixed 250 us tick steps through four routines per millisecond.
// [R9] Motion sequence runs every 500 us or 1000 us per servo period.
// [R10] Routine 1 runs motion sequence, then one low-priority slot.
// [R11] Routine 2 serial then high slot; routine 4 host communications.
// [R12] Routine 3 runs motion only at 500 us, then LEDs, high slot.
// [R13] Motion steps run in fixed order from move transfer to outputs.
// [R14] Servo step of axis 0 also performs the drive exchange.
// [R15] Each step completes for every axis before the next step.
// [R16] Three program slots per millisecond, given out by priority.
// [R17] Tasks 3 and 2 high priority; tasks 1 and 0 low.
// [R18] Both high slots always go to running high-priority tasks.
// [R19] Low-priority tasks share only the routine 1 slot.
// [R20] If all running tasks share one priority they use every slot.
// [R21] A lone high-priority task gets both high slots.
// [R22] Two high tasks take one slot each; low slot rotates per ms.
// [R23] A slot with no eligible task stays idle; sequence continues.
// [R24] Servo period selectable as 0.5 ms or 1.0 ms.
module scs_task_scheduler
  import scs_pkg::*;
#(
  parameter int N_AXES = 4,
  parameter int N_DIN = 16,
  parameter int N_DOUT = 16,
  parameter int DAC_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic servo_period_half,
  input wire logic [N_DIN-1:0] din_pins,
  input wire logic [N_DOUT-1:0] output_image,
  input wire logic [N_AXES*DAC_W-1:0] speed_ref,
  input wire logic [3:0] task_running,
  input wire logic start_req,
  input wire logic start_explicit,
  input wire logic [1:0] start_task,
  output logic [N_DIN-1:0] input_image,
  output logic [N_DOUT-1:0] dout_pins,
  output logic [N_AXES*DAC_W-1:0] dac_out,
  output logic [1:0] routine_num,
  output logic servo_cycle_start,
  output logic motion_strobe,
  output logic [2:0] motion_step,
  output logic [$clog2(N_AXES)-1:0] motion_axis,
  output logic drive_xchg,
  output logic serial_strobe,
  output logic led_strobe,
  output logic comms_strobe,
  output logic slot_strobe,
  output logic slot_valid,
  output logic [1:0] slot_task,
  output logic assign_strobe,
  output logic assign_ok,
  output logic [1:0] assign_task
);

  localparam int AXW = $clog2(N_AXES);
  localparam logic [11:0] TICK_LAST = 12'(`SCS_TICK_CYC - 1);
  localparam logic [AXW-1:0] AXIS_LAST = AXW'(N_AXES - 1);

  // Whole module state
  typedef struct packed {
    logic [11:0] tick_cnt;
    logic [1:0] routine;
    scs_state_t st;
    scs_mstep_t step;
    logic [AXW-1:0] axis;
    logic period_half;
    logic period_s1;
    logic period_s2;
    logic [N_DIN-1:0] din_s1;
    logic [N_DIN-1:0] din_s2;
    logic [N_DIN-1:0] din_latch;
    logic [N_DIN-1:0] in_image;
    logic [N_DOUT-1:0] dout;
    logic [N_AXES*DAC_W-1:0] dac;
    logic [1:0] lo_last;
    logic [1:0] hi_last;
    logic cyc_start;
    logic mot_stb;
    logic [2:0] mot_step;
    logic [AXW-1:0] mot_axis;
    logic xchg;
    logic ser_stb;
    logic led_stb;
    logic com_stb;
    logic slt_stb;
    logic slt_valid;
    logic [1:0] slt_task;
    logic asg_stb;
    logic asg_ok;
    logic [1:0] asg_task;
  } scs_regs_t;

  scs_regs_t q;
  scs_regs_t d;

  // Round robin: first set bit of mask after position last, wrapping
  function automatic logic [2:0] scs_pick(input logic [3:0] mask, input logic [1:0] last);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int i = 4; i >= 1; i--) begin
      idx = last + 2'(i);
      if (mask[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  // Highest numbered user task that is not running (command line excluded)
  function automatic logic [2:0] scs_free_top(input logic [3:0] run);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 1; i <= 3; i++) begin
      if (!run[i]) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // Next state
  always_comb begin
    logic [1:0] rt_next;
    logic [3:0] hi_run;
    logic [3:0] lo_run;
    logic [2:0] pick;
    logic [2:0] top;
    logic go_motion;
    rt_next = q.routine + 2'h1;
    hi_run = task_running & `SCS_HI_MASK;
    lo_run = task_running & `SCS_LO_MASK;
    pick = 3'h0;
    top = scs_free_top(task_running);
    go_motion = 1'b0;
    d = q;
    // One-cycle pulses fall back by default
    d.cyc_start = 1'b0;
    d.mot_stb = 1'b0;
    d.xchg = 1'b0;
    d.ser_stb = 1'b0;
    d.led_stb = 1'b0;
    d.com_stb = 1'b0;
    d.slt_stb = 1'b0;
    d.asg_stb = 1'b0;

    // Pin inputs pass two flops before use
    d.din_s1 = din_pins;
    d.din_s2 = q.din_s1;
    d.period_s1 = servo_period_half;
    d.period_s2 = q.period_s1;

    // Free-running 250 us tick, independent of sequencer progress
    d.tick_cnt = (q.tick_cnt == TICK_LAST) ? 12'h000 : q.tick_cnt + 12'h001; // see [R8]

    // Program start placement; explicit requests only succeed on a free task
    if (start_req) begin
      d.asg_stb = 1'b1;
      if (start_explicit) begin
        d.asg_ok = !task_running[start_task];
        d.asg_task = start_task;
      end else begin
        d.asg_ok = top[2]; // see [R7]
        d.asg_task = top[1:0];
      end
    end

    case (q.st)
      SCS_ST_IDLE: begin
        if (q.tick_cnt == TICK_LAST) begin
          d.routine = rt_next; // see [R8]
          // Period setting is taken once per millisecond at routine 1
          if (rt_next == `SCS_RT_MOTION) begin
            d.period_half = q.period_s2; // see [R24]
          end
          go_motion = (rt_next == `SCS_RT_MOTION) ||
                      (rt_next == `SCS_RT_LED && q.period_half); // see [R9] [R12]
          if (go_motion) begin
            d.st = SCS_ST_IO_IN; // see [R1]
            d.cyc_start = 1'b1;
          end else if (rt_next == `SCS_RT_SERIAL) begin
            d.st = SCS_ST_SERIAL; // see [R11]
          end else if (rt_next == `SCS_RT_LED) begin
            d.st = SCS_ST_LED;
          end else begin
            d.st = SCS_ST_COMMS; // see [R11]
          end
        end
      end
      SCS_ST_IO_IN: begin
        d.in_image = q.din_latch; // see [R2]
        d.st = SCS_ST_IO_DAC;
      end
      SCS_ST_IO_DAC: begin
        d.dac = speed_ref; // see [R3]
        d.st = SCS_ST_IO_DOUT;
      end
      SCS_ST_IO_DOUT: begin
        d.dout = output_image; // see [R4] [R6]
        d.st = SCS_ST_IO_LATCH;
      end
      SCS_ST_IO_LATCH: begin
        d.din_latch = q.din_s2; // see [R5]
        d.step = SCS_MS_XFER;
        d.axis = '0;
        d.st = SCS_ST_MOTION;
      end
      SCS_ST_MOTION: begin
        // Axis loop is inner, step loop outer
        d.mot_stb = 1'b1;
        d.mot_step = q.step; // see [R13]
        d.mot_axis = q.axis;
        d.xchg = (q.step == SCS_MS_SERVO) && (q.axis == '0); // see [R14]
        if (q.axis == AXIS_LAST) begin
          d.axis = '0; // see [R15]
          if (q.step == SCS_MS_OUTPUTS) begin
            d.step = SCS_MS_XFER;
            d.st = (q.routine == `SCS_RT_MOTION) ? SCS_ST_SLOT : SCS_ST_LED; // see [R10] [R12]
          end else begin
            d.step = scs_mstep_t'(q.step + 3'h1); // see [R13]
          end
        end else begin
          d.axis = q.axis + AXW'(1);
        end
      end
      SCS_ST_SERIAL: begin
        d.ser_stb = 1'b1;
        d.st = SCS_ST_SLOT;
      end
      SCS_ST_LED: begin
        d.led_stb = 1'b1; // see [R12]
        d.st = SCS_ST_SLOT;
      end
      SCS_ST_SLOT: begin
        // One program slot in routines 1, 2 and 3
        d.slt_stb = 1'b1; // see [R16]
        if (q.routine == `SCS_RT_MOTION) begin
          // Low slot: lows rotate, highs fill it only when no low runs
          if (|lo_run) begin
            pick = scs_pick(lo_run, q.lo_last); // see [R19] [R22]
            d.lo_last = pick[1:0];
          end else begin
            pick = scs_pick(hi_run, q.hi_last); // see [R20]
            if (pick[2]) begin
              d.hi_last = pick[1:0];
            end
          end
        end else begin
          // High slots: highs alternate, lows fill them only when no high runs
          if (|hi_run) begin
            pick = scs_pick(hi_run, q.hi_last); // see [R17] [R18] [R21] [R22]
            d.hi_last = pick[1:0];
          end else begin
            pick = scs_pick(lo_run, q.lo_last); // see [R20]
            if (pick[2]) begin
              d.lo_last = pick[1:0];
            end
          end
        end
        d.slt_valid = pick[2]; // see [R23]
        d.slt_task = pick[2] ? pick[1:0] : q.slt_task;
        d.st = SCS_ST_IDLE;
      end
      SCS_ST_COMMS: begin
        d.com_stb = 1'b1; // see [R11]
        d.st = SCS_ST_IDLE;
      end
      default: begin
        d.st = SCS_ST_IDLE;
      end
    endcase
  end

  // State register with synchronous reset; first tick one cycle after release
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
      q.tick_cnt <= TICK_LAST;
      q.routine <= `SCS_RST_ROUTINE;
      q.st <= SCS_ST_IDLE;
      q.step <= SCS_MS_XFER;
      q.lo_last <= `SCS_RST_LAST;
      q.hi_last <= `SCS_RST_LAST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign input_image = q.in_image;
  assign dout_pins = q.dout;
  assign dac_out = q.dac;
  assign routine_num = q.routine;
  assign servo_cycle_start = q.cyc_start;
  assign motion_strobe = q.mot_stb;
  assign motion_step = q.mot_step;
  assign motion_axis = q.mot_axis;
  assign drive_xchg = q.xchg;
  assign serial_strobe = q.ser_stb;
  assign led_strobe = q.led_stb;
  assign comms_strobe = q.com_stb;
  assign slot_strobe = q.slt_stb;
  assign slot_valid = q.slt_valid;
  assign slot_task = q.slt_task;
  assign assign_strobe = q.asg_stb;
  assign assign_ok = q.asg_ok;
  assign assign_task = q.asg_task;

endmodule

`default_nettype wire

// File: hw/scs_cfg.svh
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// Clock and fixed tick timing
`define SCS_CLK_HZ 10000000
`define SCS_TICK_US 250
// Cycles per microsecond first, so the product stays inside 32 bits
`define SCS_TICK_CYC (`SCS_TICK_US * (`SCS_CLK_HZ / 1000000))
`define SCS_ROUTINES 4

// Servo cycle periods selectable by the system setting
`define SCS_SERVO_SHORT_US 500
`define SCS_SERVO_LONG_US 1000

// Routine indices (routine 1 is index 0)
`define SCS_RT_MOTION 2'h0
`define SCS_RT_SERIAL 2'h1
`define SCS_RT_LED 2'h2
`define SCS_RT_COMMS 2'h3

// Task numbers
`define SCS_TASK_CMD 2'h0
`define SCS_TASK_LO1 2'h1
`define SCS_TASK_HI2 2'h2
`define SCS_TASK_HI3 2'h3
`define SCS_HI_MASK 4'hc
`define SCS_LO_MASK 4'h3

// Reset values
`define SCS_RST_ROUTINE 2'h3
`define SCS_RST_LAST 2'h0

`endif

// File: hw/scs_pkg.sv
`default_nettype none
package scs_pkg;

  // Sequencer states within one routine
  typedef enum logic [3:0] {
    SCS_ST_IDLE,
    SCS_ST_IO_IN,
    SCS_ST_IO_DAC,
    SCS_ST_IO_DOUT,
    SCS_ST_IO_LATCH,
    SCS_ST_MOTION,
    SCS_ST_SERIAL,
    SCS_ST_LED,
    SCS_ST_SLOT,
    SCS_ST_COMMS
  } scs_state_t;

  // Motion sequence steps, in execution order
  typedef enum logic [2:0] {
    SCS_MS_XFER,
    SCS_MS_READ_IN,
    SCS_MS_LOAD,
    SCS_MS_PROFILE,
    SCS_MS_POSITION,
    SCS_MS_SERVO,
    SCS_MS_OUTPUTS
  } scs_mstep_t;

endpackage
`default_nettype wire

// File: testbench/scs_task_scheduler_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches routine pacing, refresh order, motion walk and slot grants
module scs_task_scheduler_monitor #(
  parameter int N_AXES = 4,
  parameter int N_DIN = 16,
  parameter int N_DOUT = 16,
  parameter int DAC_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] task_running,
  input wire logic start_req,
  input wire logic [N_DIN-1:0] input_image,
  input wire logic [N_DOUT-1:0] dout_pins,
  input wire logic [N_AXES*DAC_W-1:0] dac_out,
  input wire logic [1:0] routine_num,
  input wire logic servo_cycle_start,
  input wire logic motion_strobe,
  input wire logic [2:0] motion_step,
  input wire logic [$clog2(N_AXES)-1:0] motion_axis,
  input wire logic drive_xchg,
  input wire logic serial_strobe,
  input wire logic led_strobe,
  input wire logic comms_strobe,
  input wire logic slot_strobe,
  input wire logic slot_valid,
  input wire logic [1:0] slot_task,
  input wire logic assign_strobe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic [11:0] tick_cnt_q;
  logic [1:0] rt_q;
  // Cycles since the routine number last moved
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tick_cnt_q <= 12'h9c2;
      rt_q <= 2'h3;
    end else begin
      rt_q <= routine_num;
      tick_cnt_q <= (routine_num != rt_q) ? 12'h0 : tick_cnt_q + 12'h1;
    end
  end
  property p_tick;
    routine_num != rt_q |-> tick_cnt_q == 12'h9c3 && routine_num == rt_q + 2'h1;
  endproperty
  a_tick: assert property (p_tick) else $error("routine tick spacing wrong");
  property p_refresh_first;
    servo_cycle_start |=> (!motion_strobe && !slot_strobe && !led_strobe)[*4];
  endproperty
  a_refresh_first: assert property (p_refresh_first) else $error("work before refresh");
  property p_in_image;
    $changed(input_image) |-> $past(servo_cycle_start);
  endproperty
  a_in_image: assert property (p_in_image) else $error("input image out of step");
  property p_dac;
    $changed(dac_out) |-> $past(servo_cycle_start, 2);
  endproperty
  a_dac: assert property (p_dac) else $error("speed reference out of step");
  property p_dout;
    $changed(dout_pins) |-> $past(servo_cycle_start, 3);
  endproperty
  a_dout: assert property (p_dout) else $error("output pins out of step");
  property p_motion_start;
    $rose(motion_strobe) |-> motion_step == 3'h0 && motion_axis == '0
      && $past(servo_cycle_start, 5);
  endproperty
  a_motion_start: assert property (p_motion_start) else $error("motion start wrong");
  property p_motion_walk;
    motion_strobe && $past(motion_strobe) |-> motion_axis == $past(motion_axis) + 1'b1
      && motion_step == $past(motion_step) + {2'h0, motion_axis == '0};
  endproperty
  a_motion_walk: assert property (p_motion_walk) else $error("motion order wrong");
  property p_drive;
    drive_xchg |-> motion_strobe && motion_step == 3'h5 && motion_axis == '0;
  endproperty
  a_drive: assert property (p_drive) else $error("drive exchange misplaced");
  property p_strobes;
    (!serial_strobe || routine_num == 2'h1) && (!led_strobe || routine_num == 2'h2)
      && (!comms_strobe || routine_num == 2'h3);
  endproperty
  a_strobes: assert property (p_strobes) else $error("routine work misplaced");
  property p_hi_slot;
    slot_strobe && routine_num != 2'h0 && |$past(task_running[3:2]) |-> slot_valid && slot_task[1];
  endproperty
  a_hi_slot: assert property (p_hi_slot) else $error("high slot not to high task");
  property p_assign;
    start_req |=> assign_strobe;
  endproperty
  a_assign: assert property (p_assign) else $error("start request unanswered");
  c_half: cover property (servo_cycle_start && routine_num == 2'h2);
  c_drive: cover property (drive_xchg);
  c_idle: cover property (slot_strobe && !slot_valid);
endmodule
bind scs_task_scheduler scs_task_scheduler_monitor #(.N_AXES(N_AXES), .N_DIN(N_DIN),
  .N_DOUT(N_DOUT), .DAC_W(DAC_W)) u_mon (.sys_clk(sys_clk), .resetn(resetn),
  .task_running(task_running), .start_req(start_req), .input_image(input_image),
  .dout_pins(dout_pins), .dac_out(dac_out), .routine_num(routine_num),
  .servo_cycle_start(servo_cycle_start), .motion_strobe(motion_strobe),
  .motion_step(motion_step), .motion_axis(motion_axis), .drive_xchg(drive_xchg),
  .serial_strobe(serial_strobe), .led_strobe(led_strobe), .comms_strobe(comms_strobe),
  .slot_strobe(slot_strobe), .slot_valid(slot_valid), .slot_task(slot_task),
  .assign_strobe(assign_strobe));
`default_nettype wire

// File: testbench/scs_task_partner.sv
`timescale 1ns/1ps
`default_nettype none
// User tasks: run on granted slots and refresh the output images
module scs_task_partner (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic [3:0] run_mask,
  input wire logic slot_strobe,
  input wire logic slot_valid,
  input wire logic [1:0] slot_task,
  output logic [3:0] task_running,
  output logic [15:0] output_image,
  output logic [63:0] speed_ref,
  output logic [3:0][7:0] gcnt
);
  assign task_running = run_mask;
  assign speed_ref = {output_image, ~output_image, output_image ^ 16'h5a5a, 16'h0f0f};
  // Only a granted task reacts; the pins are never acted on directly
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      gcnt <= '0;
      output_image <= 16'h0;
    end else if (slot_strobe && slot_valid) begin
      gcnt[slot_task] <= gcnt[slot_task] + 8'h1;
      output_image <= output_image + 16'h1357;
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_servo_cycle_task_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_servo_cycle_task_scheduler;
  logic sys_clk = 1'b0, resetn = 1'b0, half = 1'b0, clr = 1'b1;
  logic [15:0] din = 16'h0;
  logic [3:0] mask = 4'h0;
  logic start_req = 1'b0, start_explicit = 1'b0;
  logic [1:0] start_task = 2'h0;
  logic [3:0] task_running;
  logic [15:0] output_image, input_image, dout_pins;
  logic [63:0] speed_ref, dac_out;
  logic [1:0] routine_num, slot_task, assign_task;
  logic servo_cycle_start, slot_strobe, slot_valid, assign_strobe, assign_ok;
  logic [3:0][7:0] gcnt;
  int error_cnt = 0, cmp_count = 0;
  // Clock at 10 MHz
  always #50 sys_clk = ~sys_clk;
  scs_task_scheduler u_dut (.sys_clk(sys_clk), .resetn(resetn), .servo_period_half(half),
    .din_pins(din), .output_image(output_image), .speed_ref(speed_ref),
    .task_running(task_running), .start_req(start_req), .start_explicit(start_explicit),
    .start_task(start_task), .input_image(input_image), .dout_pins(dout_pins),
    .dac_out(dac_out), .routine_num(routine_num), .servo_cycle_start(servo_cycle_start),
    .motion_strobe(), .motion_step(), .motion_axis(), .drive_xchg(), .serial_strobe(),
    .led_strobe(), .comms_strobe(), .slot_strobe(slot_strobe), .slot_valid(slot_valid),
    .slot_task(slot_task), .assign_strobe(assign_strobe), .assign_ok(assign_ok),
    .assign_task(assign_task));
  scs_task_partner u_part (.sys_clk(sys_clk), .clr(clr), .run_mask(mask),
    .slot_strobe(slot_strobe), .slot_valid(slot_valid), .slot_task(slot_task),
    .task_running(task_running), .output_image(output_image), .speed_ref(speed_ref),
    .gcnt(gcnt));
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Waits for a servo cycle start, any routine or routine 1 only
  task automatic wait_start(input bit any);
    int n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (!(servo_cycle_start === 1'b1 && (any || routine_num === 2'h0)) && n < 12000);
    if (n >= 12000) begin
      error_cnt++;
      $display("BAD %0t no servo cycle", $time);
      final_report;
    end
  endtask
  // One start request and its answer
  task automatic t_assign(input logic [3:0] m, input logic ex, input logic [1:0] tk,
      input logic ok, input logic [1:0] et);
    @(posedge sys_clk);
    mask <= m;
    start_req <= 1'b1;
    start_explicit <= ex;
    start_task <= tk;
    @(posedge sys_clk);
    start_req <= 1'b0;
    #1;
    `CHK(assign_strobe, 1'b1)
    `CHK(assign_ok, ok)
    if (ok) `CHK(assign_task, et)
  endtask
  // Input image lags the pins one servo cycle; outputs follow the images
  task automatic t_refresh;
    @(posedge sys_clk);
    mask <= 4'h8;
    half <= 1'b1;
    din <= 16'ha5c3;
    wait_start(1'b1);
    repeat (10) @(posedge sys_clk);
    din <= 16'h3c5a;
    wait_start(1'b1);
    @(posedge sys_clk);
    #1;
    `CHK(input_image, 16'ha5c3)
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(dac_out, speed_ref)
    `CHK(dout_pins, output_image)
    wait_start(1'b1);
    @(posedge sys_clk);
    #1;
    `CHK(input_image, 16'h3c5a)
  endtask
  // Counts slot grants and servo starts over whole milliseconds
  task automatic t_slots(input logic [3:0] m, input logic h, input int ms,
      input logic [3:0][7:0] exp, input int starts);
    int s = 1;
    @(posedge sys_clk);
    mask <= m;
    half <= h;
    repeat (10) @(posedge sys_clk);
    wait_start(1'b0);
    // Window ends after the last slot of the last millisecond (routine 4 has none)
    for (int i = 1; i < ms * 10000 - 2500; i++) begin
      @(posedge sys_clk);
      clr <= (i == 1);
      #1;
      if (servo_cycle_start === 1'b1) s++;
    end
    `CHK(s, starts)
    `CHK(gcnt, exp)
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    clr <= 1'b0;
    t_assign(4'h8, 1'b0, 2'h0, 1'b1, 2'h2);
    t_assign(4'hc, 1'b0, 2'h0, 1'b1, 2'h1);
    t_assign(4'he, 1'b0, 2'h0, 1'b0, 2'h0);
    t_assign(4'h0, 1'b0, 2'h0, 1'b1, 2'h3);
    t_assign(4'h8, 1'b1, 2'h3, 1'b0, 2'h0);
    t_assign(4'h8, 1'b1, 2'h0, 1'b1, 2'h0);
    t_refresh;
    t_slots(4'hb, 1'b1, 2, {8'h4, 8'h0, 8'h1, 8'h1}, 4);
    t_slots(4'hf, 1'b0, 2, {8'h2, 8'h2, 8'h1, 8'h1}, 2);
    t_slots(4'h4, 1'b0, 1, {8'h0, 8'h3, 8'h0, 8'h0}, 1);
    t_slots(4'h0, 1'b1, 1, {8'h0, 8'h0, 8'h0, 8'h0}, 2);
    final_report;
  end
endmodule
`default_nettype wire
